// [hdl/lusc_regs.sv]
// status and control register bank for the four line channels
`timescale 1ns/100ps
`default_nettype none
module lusc_regs
	import lusc_pkg::*;
#(
	parameter int NCH         = NUM_CHAN,
	parameter int SRST_CYCLES = SOFT_RST_CYCLES
) (
	// clock and reset
	input  wire logic            clock_i,
	input  wire logic            reset_i,
	// register port
	input  wire lusc_req_t       req_i,
	output logic      [7:0]      rd_data_o,
	// line status pins, asynchronous
	input  wire logic [NCH-1:0]  los_i,
	input  wire logic [NCH-1:0]  fault_i,
	input  wire logic [NCH-1:0]  ais_i,
	// interrupt
	output logic                 irq_o,
	// per-channel controls
	output logic      [NCH-1:0]  digital_loopback_enable_o,
	output logic      [NCH-1:0]  alarm_criteria_select_o,
	output logic      [NCH-1:0]  driver_hiz_o,
	output logic      [NCH-1:0]  tx_all_ones_o,
	output logic      [NCH-1:0]  alarm_insert_o,
	// global controls
	output lusc_cfg_t            cfg_o,
	output logic      [3:0]      monitor_channel_select_o,
	output lusc_mon_t            monitor_o,
	output logic                 soft_reset_active_o
);
	localparam int CNT_W = $clog2(SRST_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SRST_CYCLES);

	// synchronised status
	logic [NCH-1:0] los_s;
	logic [NCH-1:0] fault_s;
	logic [NCH-1:0] ais_s;

	// masks and per-channel configuration
	logic [NCH-1:0] signal_loss_interrupt_mask;
	logic [NCH-1:0] driver_fault_interrupt_mask;
	logic [NCH-1:0] alarm_interrupt_mask;
	logic [NCH-1:0] auto_all_ones_enable;

	// interrupt status latches
	logic [NCH-1:0] loss_interrupt_status;
	logic [NCH-1:0] fault_interrupt_status;
	logic [NCH-1:0] alarm_interrupt_status;

	// software reset sequencing
	logic [CNT_W-1:0] soft_count;
	logic [7:0]       software_reset_trigger;
	logic             regs_reset;

	// decoded accesses
	logic wr_ok;
	logic rd_loss_status;
	logic rd_fault_status;
	logic rd_alarm_status;
	logic [7:0] next_rd_data;
	lusc_mon_t  next_mon;

	assign regs_reset = reset_i | soft_reset_active_o;
	// writes land only outside a reset cycle
	assign wr_ok = req_i.wr & ~soft_reset_active_o;

	// R1 clear on loss read
	assign rd_loss_status  = req_i.rd && (req_i.addr == ADDR_LOSS_STATUS);
	// R2 clear on fault read
	assign rd_fault_status = req_i.rd && (req_i.addr == ADDR_FAULT_STATUS);
	// R3 clear on alarm read
	assign rd_alarm_status = req_i.rd && (req_i.addr == ADDR_ALARM_STATUS);

	lusc_sync #(
		.WIDTH (NCH)
	) u_sync_los (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.async_i (los_i),
		.sync_o  (los_s)
	);

	lusc_sync #(
		.WIDTH (NCH)
	) u_sync_fault (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.async_i (fault_i),
		.sync_o  (fault_s)
	);

	lusc_sync #(
		.WIDTH (NCH)
	) u_sync_ais (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.async_i (ais_i),
		.sync_o  (ais_s)
	);

	// R1 loss event latch
	lusc_event_latch #(
		.WIDTH (NCH)
	) u_loss_latch (
		.clock_i  (clock_i),
		.reset_i  (regs_reset),
		.status_i (los_s),
		.mask_i   (signal_loss_interrupt_mask),
		.clear_i  (rd_loss_status),
		.flag_o   (loss_interrupt_status)
	);

	// R2 fault event latch
	lusc_event_latch #(
		.WIDTH (NCH)
	) u_fault_latch (
		.clock_i  (clock_i),
		.reset_i  (regs_reset),
		.status_i (fault_s),
		.mask_i   (driver_fault_interrupt_mask),
		.clear_i  (rd_fault_status),
		.flag_o   (fault_interrupt_status)
	);

	// R3 alarm event latch
	lusc_event_latch #(
		.WIDTH (NCH)
	) u_alarm_latch (
		.clock_i  (clock_i),
		.reset_i  (regs_reset),
		.status_i (ais_s),
		.mask_i   (alarm_interrupt_mask),
		.clear_i  (rd_alarm_status),
		.flag_o   (alarm_interrupt_status)
	);

	// R4 one microsecond reset cycle
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			soft_count          <= '0;
			soft_reset_active_o <= 1'b0;
		end
		else if (req_i.wr && (req_i.addr == ADDR_SOFT_RESET) && !soft_reset_active_o)
		begin
			soft_count          <= CNT_LOAD;
			soft_reset_active_o <= 1'b1;
		end
		else if (soft_count > CNT_W'(1))
		begin
			soft_count <= soft_count - CNT_W'(1);
		end
		else
		begin
			soft_count          <= '0;
			soft_reset_active_o <= 1'b0;
		end
	end

	// R5 trigger content never written
	always_ff @(posedge clock_i)
	begin
		software_reset_trigger <= RST_SOFT_RESET;
	end

	// R22 R23 R20 interrupt masks
	always_ff @(posedge clock_i)
	begin
		if (regs_reset)
		begin
			signal_loss_interrupt_mask  <= RST_CHAN;
			driver_fault_interrupt_mask <= RST_CHAN;
			alarm_interrupt_mask        <= RST_CHAN;
		end
		else if (wr_ok)
		begin
			if (req_i.addr == ADDR_LOSS_MASK)
			begin
				signal_loss_interrupt_mask <= req_i.wdata[NCH-1:0];
			end
			if (req_i.addr == ADDR_FAULT_MASK)
			begin
				driver_fault_interrupt_mask <= req_i.wdata[NCH-1:0];
			end
			if (req_i.addr == ADDR_ALARM_MASK)
			begin
				alarm_interrupt_mask <= req_i.wdata[NCH-1:0];
			end
		end
	end

	// R9 R10 R18 per-channel controls
	always_ff @(posedge clock_i)
	begin
		if (regs_reset)
		begin
			digital_loopback_enable_o <= RST_CHAN;
			alarm_criteria_select_o   <= RST_CHAN;
			driver_hiz_o              <= RST_CHAN;
			auto_all_ones_enable      <= RST_CHAN;
		end
		else if (wr_ok)
		begin
			if (req_i.addr == ADDR_LOOPBACK)
			begin
				digital_loopback_enable_o <= req_i.wdata[NCH-1:0];
			end
			if (req_i.addr == ADDR_CRITERIA)
			begin
				alarm_criteria_select_o <= req_i.wdata[NCH-1:0];
			end
			if (req_i.addr == ADDR_DRIVER_OE)
			begin
				driver_hiz_o <= req_i.wdata[NCH-1:0];
			end
			if (req_i.addr == ADDR_AUTO_ONES)
			begin
				auto_all_ones_enable <= req_i.wdata[NCH-1:0];
			end
		end
	end

	// R12 R13 R14 R15 R16 R17 global fields
	always_ff @(posedge clock_i)
	begin
		if (regs_reset)
		begin
			cfg_o <= RST_CFG;
		end
		else if (wr_ok && (req_i.addr == ADDR_GLOBAL))
		begin
			cfg_o.alarm_insert_enable     <= req_i.wdata[GCF_INSERT_POS];
			cfg_o.short_protect_disable   <= req_i.wdata[GCF_SHORT_POS];
			cfg_o.line_code_ami           <= req_i.wdata[GCF_CODE_POS];
			cfg_o.jitter_fifo_depth       <= req_i.wdata[GCF_DEPTH_POS];
			cfg_o.jitter_bandwidth_select <= req_i.wdata[GCF_BW_POS];
			cfg_o.jitter_atten_placement  <= req_i.wdata[GCF_PLACE_LSB +: 2];
		end
	end

	// R8 monitor select store
	always_ff @(posedge clock_i)
	begin
		if (regs_reset)
		begin
			monitor_channel_select_o <= RST_MON_SEL;
		end
		else if (wr_ok && (req_i.addr == ADDR_PERF_MON))
		begin
			monitor_channel_select_o <= req_i.wdata[3:0];
		end
	end

	// reserved codes monitor nothing, safer than guessing a channel
	always_comb
	begin
		next_mon = RST_MON;
		// R6 receiver monitoring
		if (monitor_channel_select_o >= MON_RX1 && monitor_channel_select_o <= MON_RX3)
		begin
			next_mon.active = 1'b1;
			next_mon.is_tx  = 1'b0;
			next_mon.chan   = monitor_channel_select_o[1:0];
		end
		// R7 transmitter monitoring
		else if (monitor_channel_select_o >= MON_TX1 && monitor_channel_select_o <= MON_TX3)
		begin
			next_mon.active = 1'b1;
			next_mon.is_tx  = 1'b1;
			next_mon.chan   = monitor_channel_select_o[1:0];
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (regs_reset)
		begin
			monitor_o <= RST_MON;
		end
		else
		begin
			monitor_o <= next_mon;
		end
	end

	// R11 R12 loss-driven insertion
	always_ff @(posedge clock_i)
	begin
		if (regs_reset)
		begin
			tx_all_ones_o  <= RST_CHAN;
			alarm_insert_o <= RST_CHAN;
		end
		else
		begin
			tx_all_ones_o  <= auto_all_ones_enable & los_s;
			alarm_insert_o <= {NCH{cfg_o.alarm_insert_enable}} & los_s;
		end
	end

	// R25 interrupt while any flag set
	always_ff @(posedge clock_i)
	begin
		if (regs_reset)
		begin
			irq_o <= 1'b0;
		end
		else
		begin
			irq_o <= |{loss_interrupt_status, fault_interrupt_status, alarm_interrupt_status};
		end
	end

	// read mux, upper bits read zero
	always_comb
	begin
		next_rd_data = RD_NONE;
		unique case (req_i.addr)
			// R24 live loss status
			ADDR_LOSS_STATUS:  next_rd_data[NCH-1:0] = los_s;
			ADDR_FAULT_STATUS: next_rd_data[NCH-1:0] = fault_s;
			ADDR_LOSS_MASK:    next_rd_data[NCH-1:0] = signal_loss_interrupt_mask;
			ADDR_FAULT_MASK:   next_rd_data[NCH-1:0] = driver_fault_interrupt_mask;
			ADDR_LOSS_INT:     next_rd_data[NCH-1:0] = loss_interrupt_status;
			ADDR_FAULT_INT:    next_rd_data[NCH-1:0] = fault_interrupt_status;
			ADDR_PERF_MON:     next_rd_data[3:0]     = monitor_channel_select_o;
			ADDR_LOOPBACK:     next_rd_data[NCH-1:0] = digital_loopback_enable_o;
			ADDR_CRITERIA:     next_rd_data[NCH-1:0] = alarm_criteria_select_o;
			ADDR_AUTO_ONES:    next_rd_data[NCH-1:0] = auto_all_ones_enable;
			ADDR_GLOBAL:       next_rd_data[6:0]     = cfg_o;
			ADDR_DRIVER_OE:    next_rd_data[NCH-1:0] = driver_hiz_o;
			// R19 live alarm status
			ADDR_ALARM_STATUS: next_rd_data[NCH-1:0] = ais_s;
			ADDR_ALARM_MASK:   next_rd_data[NCH-1:0] = alarm_interrupt_mask;
			ADDR_ALARM_INT:    next_rd_data[NCH-1:0] = alarm_interrupt_status;
			// write-only trigger and unmapped addresses read zero
			default:           next_rd_data = RD_NONE;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (regs_reset)
		begin
			rd_data_o <= RD_NONE;
		end
		else if (req_i.rd)
		begin
			rd_data_o <= next_rd_data;
		end
	end
endmodule
`default_nettype wire

// [hdl/lusc_pkg.sv]
// constants and types for the line unit status and control register bank
// Summary of operation
// R1: loss interrupt bit sets on masked loss transition, clears on loss status read.
// R2: fault interrupt bit sets on masked fault transition, clears on fault status read.
// R3: alarm interrupt bit sets on masked alarm transition, clears on alarm status read.
// R4: any write to software reset starts 1 us cycle returning all registers to default; a write while a cycle is running is ignored.
// R5: software reset register is write-only, keeps its all-ones content on writes.
// R6: monitor select codes 0001-0011 pick receivers 1-3; 0100-0111 reserved.
// R7: monitor select codes 1001-1011 pick transmitters 1-3; 1100-1111 reserved.
// R8: monitor codes 0000 and 1000 mean no monitoring; 0000 after reset.
// R9: per-channel digital loopback enabled by 1, normal by 0, reset 0.
// R10: per-channel criteria bit: 0 selects G.775, 1 selects ETSI 300 233.
// R11: auto all-ones bit sends all ones to line while loss persists.
// R12: global bit 6 enables alarm insertion toward system side on loss.
// R13: global bit 5 at 0 enables, at 1 disables short circuit protection.
// R14: global bit 4 selects HDB3 at 0 and AMI at 1.
// R15: global bit 3 selects 32-bit store at 0, 64-bit store at 1.
// R16: global bit 2 selects 1.7 Hz corner at 0, 6.6 Hz at 1.
// R17: placement field: 01 transmit path, 11 receive path, 00 and 10 unused.
// R18: per-channel driver output enable bit: 0 active, 1 high impedance.
// R19: alarm status register reads 1 per channel while alarm is detected.
// R20: alarm interrupt mask bit allows interrupts at 1, blocks at 0.
// R21: software keeps reserved upper four bits of channel registers at zero.
// R22: loss interrupt mask bit permits at 1, blocks at 0, default 0.
// R23: fault interrupt mask bit permits at 1, blocks at 0, default 0.
// R24: loss status register shows 1 for each channel currently losing signal.
// R25: interrupt output asserted while any interrupt status bit is set.
package lusc_pkg;
	localparam int NUM_CHAN = 4;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 8;

	localparam logic [7:0] ADDR_LOSS_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_FAULT_STATUS  = 8'h05;
	localparam logic [7:0] ADDR_LOSS_MASK     = 8'h06;
	localparam logic [7:0] ADDR_FAULT_MASK    = 8'h07;
	localparam logic [7:0] ADDR_LOSS_INT      = 8'h08;
	localparam logic [7:0] ADDR_FAULT_INT     = 8'h09;
	localparam logic [7:0] ADDR_SOFT_RESET    = 8'h0a;
	localparam logic [7:0] ADDR_PERF_MON      = 8'h0b;
	localparam logic [7:0] ADDR_LOOPBACK      = 8'h0c;
	localparam logic [7:0] ADDR_CRITERIA      = 8'h0d;
	localparam logic [7:0] ADDR_AUTO_ONES     = 8'h0e;
	localparam logic [7:0] ADDR_GLOBAL        = 8'h0f;
	localparam logic [7:0] ADDR_DRIVER_OE     = 8'h12;
	localparam logic [7:0] ADDR_ALARM_STATUS  = 8'h13;
	localparam logic [7:0] ADDR_ALARM_MASK    = 8'h14;
	localparam logic [7:0] ADDR_ALARM_INT     = 8'h15;

	localparam logic [3:0] RST_CHAN           = 4'h0;
	localparam logic [3:0] RST_MON_SEL        = 4'h0;
	localparam logic [7:0] RST_SOFT_RESET     = 8'hff;
	localparam logic [7:0] RD_NONE            = 8'h00;

	// global configuration field positions
	localparam int GCF_INSERT_POS  = 6;
	localparam int GCF_SHORT_POS   = 5;
	localparam int GCF_CODE_POS    = 4;
	localparam int GCF_DEPTH_POS   = 3;
	localparam int GCF_BW_POS      = 2;
	localparam int GCF_PLACE_LSB   = 0;

	// monitor select codes
	localparam logic [3:0] MON_NONE_RX = 4'h0;
	localparam logic [3:0] MON_RX1     = 4'h1;
	localparam logic [3:0] MON_RX3     = 4'h3;
	localparam logic [3:0] MON_NONE_TX = 4'h8;
	localparam logic [3:0] MON_TX1     = 4'h9;
	localparam logic [3:0] MON_TX3     = 4'hb;

	localparam int CLK_PERIOD_NS    = 25;
	localparam int SOFT_RST_TIME_NS = 1000;
	localparam int SOFT_RST_CYCLES  = (SOFT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lusc_req_t;

	typedef struct packed {
		logic       alarm_insert_enable;
		logic       short_protect_disable;
		logic       line_code_ami;
		logic       jitter_fifo_depth;
		logic       jitter_bandwidth_select;
		logic [1:0] jitter_atten_placement;
	} lusc_cfg_t;

	typedef struct packed {
		logic       active;
		logic       is_tx;
		logic [1:0] chan;
	} lusc_mon_t;

	localparam lusc_cfg_t RST_CFG = '{default: 1'b0};
	localparam lusc_mon_t RST_MON = '{default: 1'b0};
endpackage

// [hdl/lusc_sync.sv]
// two-stage synchroniser for the per-channel line status pins
`timescale 1ns/100ps
`default_nettype none
module lusc_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             clock_i,
	input  wire logic             reset_i,
	// pin side and clock side
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;

	// first stage feeds only the second
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			stage1 <= '0;
			sync_o <= '0;
		end
		else
		begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule
`default_nettype wire

// [hdl/lusc_event_latch.sv]
// per-channel sticky latch set on any masked transition of a status line
`timescale 1ns/100ps
`default_nettype none
module lusc_event_latch #(
	parameter int WIDTH = 4
) (
	// clock and resets
	input  wire logic             clock_i,
	input  wire logic             reset_i,
	// status, mask and clear
	input  wire logic [WIDTH-1:0] status_i,
	input  wire logic [WIDTH-1:0] mask_i,
	input  wire logic             clear_i,
	output logic      [WIDTH-1:0] flag_o
);
	logic [WIDTH-1:0] last_status;
	logic [WIDTH-1:0] next_flag;

	// set beats clear in the same cycle
	always_comb
	begin
		next_flag = clear_i ? '0 : flag_o;
		next_flag = next_flag | ((status_i ^ last_status) & mask_i);
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			flag_o <= '0;
		end
		else
		begin
			flag_o <= next_flag;
		end
	end

	// edge history tracks even through a soft reset, avoiding a false event after it
	always_ff @(posedge clock_i)
	begin
		last_status <= status_i;
	end
endmodule
`default_nettype wire

// [verification/lusc_regs_props.sv]
// port-level assertions for the line unit register bank
`timescale 1ns/100ps
`default_nettype none
module lusc_regs_props
	import lusc_pkg::*;
#(
	parameter int SRST_CYCLES = SOFT_RST_CYCLES
) (
	// clock and reset
	input  wire logic       clock_i,
	input  wire logic       reset_i,
	// register port
	input  wire lusc_req_t  req_i,
	input  wire logic [7:0] rd_data_o,
	// watched outputs
	input  wire logic       irq_o,
	input  wire logic [3:0] digital_loopback_enable_o,
	input  wire logic [3:0] alarm_insert_o,
	input  wire lusc_cfg_t  cfg_o,
	input  wire logic [3:0] monitor_channel_select_o,
	input  wire lusc_mon_t  monitor_o,
	input  wire logic       soft_reset_active_o
);
	logic [7:0] srst_len;
	logic       exp_act;
	logic       exp_tx;

	default clocking @(posedge clock_i);
	endclocking
	default disable iff (reset_i);

	// codes 1-3 and 9-b select a channel, the rest do not
	assign exp_act = !monitor_channel_select_o[2] && monitor_channel_select_o[1:0] != 2'b00;
	assign exp_tx  = monitor_channel_select_o[3];

	always_ff @(posedge clock_i)
	begin
		if (reset_i || !soft_reset_active_o)
			srst_len <= 8'h00;
		else
			srst_len <= srst_len + 8'h01;
	end

	sequence s_soft_write;
		req_i.wr && req_i.addr == 8'h0a && !soft_reset_active_o;
	endsequence
	sequence s_flag_read;
		req_i.rd && req_i.addr inside {8'h08, 8'h09, 8'h15};
	endsequence

	a_soft_start: assert property (s_soft_write |-> ##[1:2] soft_reset_active_o)
		else $error("soft reset did not start");
	a_soft_length: assert property ($fell(soft_reset_active_o) |-> srst_len == SRST_CYCLES)
		else $error("soft reset length wrong");
	a_soft_defaults: assert property (soft_reset_active_o [*2] |-> cfg_o == '0
		&& !irq_o && digital_loopback_enable_o == 4'h0 && alarm_insert_o == 4'h0
		&& rd_data_o == 8'h00) else $error("outputs not at default in soft reset");
	a_trigger_read: assert property (req_i.rd && req_i.addr == 8'h0a |=> rd_data_o == 8'h00)
		else $error("write-only register read not zero");
	a_irq_flag: assert property (s_flag_read ##1 rd_data_o != 8'h00 |-> irq_o)
		else $error("flag set without interrupt");
	a_insert_gated: assert property (!cfg_o.alarm_insert_enable [*3] |-> alarm_insert_o == 4'h0)
		else $error("alarm inserted while disabled");
	// the soft reset cycle zeroes the read data one edge after it starts
	a_rd_hold: assert property (!req_i.rd && !soft_reset_active_o
		&& !(req_i.wr && req_i.addr == 8'h0a)
		|=> $stable(rd_data_o)) else $error("read data changed without read");
	a_mon_decode: assert property (!soft_reset_active_o |-> monitor_o.active == $past(exp_act)
		&& (!monitor_o.active || monitor_o.is_tx == $past(exp_tx)))
		else $error("monitor decode wrong");
endmodule

bind lusc_regs lusc_regs_props #(.SRST_CYCLES(SRST_CYCLES)) u_props (
	.clock_i(clock_i), .reset_i(reset_i), .req_i(req_i), .rd_data_o(rd_data_o),
	.irq_o(irq_o), .digital_loopback_enable_o(digital_loopback_enable_o),
	.alarm_insert_o(alarm_insert_o), .cfg_o(cfg_o),
	.monitor_channel_select_o(monitor_channel_select_o), .monitor_o(monitor_o),
	.soft_reset_active_o(soft_reset_active_o));
`default_nettype wire

// [verification/lusc_regs_tb.sv]
// self-checking bench for the line unit register bank
`timescale 1ns/100ps
`default_nettype none
module lusc_regs_tb
	import lusc_pkg::*;
;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} lusc_row_t;

	localparam int SRST = 4;
	logic       clock_i;
	logic       reset_i;
	lusc_req_t  req;
	logic [3:0] los;
	logic [3:0] fault;
	logic [3:0] alarm_signal_status;
	logic [3:0] digital_loopback_config;
	logic [3:0] alarm_criteria_config;
	logic [3:0] hiz;
	logic [3:0] tao;
	logic [3:0] ins;
	logic [3:0] mcs;
	logic [7:0] rdata;
	logic       irq;
	logic       sra;
	logic       e;
	lusc_cfg_t  cfg;
	lusc_mon_t  mon;
	int         bad_count = 0;
	int         compares = 0;
	int         cycles = 0;
	int         i;
	// reserved upper bits kept at zero; read-only and unmapped writes ignored
	lusc_row_t  rows [13] = '{'{8'h06, 8'h0f, 8'h0f}, '{8'h07, 8'h0f, 8'h0f},
		'{8'h0b, 8'h05, 8'h05}, '{8'h0c, 8'h0f, 8'h0f}, '{8'h0d, 8'h0a, 8'h0a},
		'{8'h0e, 8'h0f, 8'h0f}, '{8'h0f, 8'h2a, 8'h2a}, '{8'h0f, 8'h7f, 8'h7f},
		'{8'h12, 8'h0c, 8'h0c}, '{8'h14, 8'h0f, 8'h0f}, '{8'h08, 8'hff, 8'h00},
		'{8'h13, 8'hff, 8'h00}, '{8'h10, 8'hff, 8'h00}};

	lusc_regs #(.SRST_CYCLES(SRST)) dut (
		.clock_i(clock_i), .reset_i(reset_i), .req_i(req), .rd_data_o(rdata),
		.los_i(los), .fault_i(fault), .ais_i(alarm_signal_status), .irq_o(irq),
		.digital_loopback_enable_o(digital_loopback_config), .alarm_criteria_select_o(alarm_criteria_config),
		.driver_hiz_o(hiz), .tx_all_ones_o(tao), .alarm_insert_o(ins), .cfg_o(cfg),
		.monitor_channel_select_o(mcs), .monitor_o(mon), .soft_reset_active_o(sra));

	task automatic summarize();
		if (bad_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock_i);
		#2;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		idle(1);
		req.wr = 1'b0;
		// quiet cycle keeps the next call out of this time step
		idle(1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		idle(1);
		req.rd = 1'b0;
		chk(rdata, x);
		idle(1);
	endtask

	// soft reset lasts a few cycles, so the wait is short
	task automatic wait_sra(input logic v);
		int n;
		n = 0;
		while (sra !== v && n < 60)
		begin
			idle(1);
			n++;
		end
		chk({7'h0, sra}, {7'h0, v});
	endtask

	initial
	begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end

	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			summarize();
		end
	end

	initial
	begin
		reset_i = 1'b1;
		req = '0;
		los = 4'h0;
		fault = 4'h0;
		alarm_signal_status = 4'h0;
		repeat (4) @(posedge clock_i);
		#2 reset_i = 1'b0;
		chk({7'h0, irq}, 8'h00);
		for (i = 0; i < 13; i++)
			rd(rows[i].a, 8'h00);
		rd(8'h0a, 8'h00);
		for (i = 0; i < 13; i++)
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		chk({4'h0, digital_loopback_config}, 8'h0f);
		chk({4'h0, alarm_criteria_config}, 8'h0a);
		chk({4'h0, hiz}, 8'h0c);
		chk({1'b0, cfg}, 8'h7f);
		chk({4'h0, mcs}, 8'h05);
		los[0] = 1'b1;
		idle(5);
		rd(8'h08, 8'h01);
		chk({7'h0, irq}, 8'h01);
		rd(8'h04, 8'h01);
		rd(8'h08, 8'h00);
		idle(2);
		chk({7'h0, irq}, 8'h00);
		los[0] = 1'b0;
		idle(5);
		rd(8'h08, 8'h01);
		rd(8'h04, 8'h00);
		wr(8'h07, 8'h08);
		fault = 4'ha;
		idle(5);
		rd(8'h09, 8'h08);
		rd(8'h05, 8'h0a);
		rd(8'h09, 8'h00);
		wr(8'h14, 8'h04);
		alarm_signal_status = 4'h6;
		idle(5);
		rd(8'h15, 8'h04);
		rd(8'h13, 8'h06);
		rd(8'h15, 8'h00);
		los = 4'h3;
		idle(5);
		chk({4'h0, tao}, 8'h03);
		chk({4'h0, ins}, 8'h03);
		wr(8'h0e, 8'h01);
		wr(8'h0f, 8'h00);
		idle(3);
		chk({4'h0, tao}, 8'h01);
		chk({4'h0, ins}, 8'h00);
		for (i = 0; i < 16; i++)
		begin
			wr(8'h0b, 8'(i));
			idle(1);
			e = !i[2] && i[1:0] != 2'b00;
			chk({4'h0, mon}, {4'h0, e, e & i[3], e ? i[1:0] : 2'b00});
		end
		wr(8'h0c, 8'h05);
		wr(8'h0a, 8'h00);
		wait_sra(1'b1);
		wr(8'h0c, 8'h0f);
		wait_sra(1'b0);
		rd(8'h0c, 8'h00);
		rd(8'h0b, 8'h00);
		rd(8'h0e, 8'h00);
		rd(8'h0a, 8'h00);
		idle(3);
		chk({4'h0, tao}, 8'h00);
		// hard reset in mid-run
		wr(8'h0c, 8'h0f);
		chk({4'h0, digital_loopback_config}, 8'h0f);
		reset_i = 1'b1;
		idle(4);
		reset_i = 1'b0;
		chk({4'h0, digital_loopback_config}, 8'h00);
		rd(8'h0c, 8'h00);
		summarize();
	end
endmodule
`default_nettype wire
